// file: rtl/cpu_seq_pkg.sv
`default_nettype none
package cpu_seq_pkg;
  localparam int PC_W        = 12;
  localparam int PCL_W       = 8;
  localparam int DATA_W      = 8;
  localparam int INSTR_W     = 16;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W        = 3;
  localparam int DEPTH_W     = 4;
  localparam int AXI_ADDR_W  = 5;
  localparam int AXI_DATA_W  = 32;

  localparam logic [PC_W-1:0]    RESET_VECTOR = 12'h000;
  localparam logic [PC_W-1:0]    INT_VECTOR   = 12'h004;
  localparam logic [PC_W-1:0]    PC_ONE       = 12'h001;
  localparam logic [SP_W-1:0]    SP_ONE       = 3'h1;
  localparam logic [SP_W-1:0]    SP_RESET     = 3'h0;
  localparam logic [DEPTH_W-1:0] DEPTH_ONE    = 4'h1;
  localparam logic [DEPTH_W-1:0] DEPTH_FULL   = 4'h8;

  // Instruction word fields
  localparam int OPC_LSB  = 12;
  localparam int FUNC_LSB = 8;
  localparam logic [INSTR_W-1:0] NOP_WORD = 16'h0000;

  localparam logic [3:0] OP_NOP    = 4'h0;
  localparam logic [3:0] OP_ALU    = 4'h1;
  localparam logic [3:0] OP_JMP    = 4'h2;
  localparam logic [3:0] OP_CALL   = 4'h3;
  localparam logic [3:0] OP_RET    = 4'h4;
  localparam logic [3:0] OP_RETURN_FROM_INTERRUPT   = 4'h5;
  localparam logic [3:0] OP_SZ     = 4'h6;
  localparam logic [3:0] OP_SDZ    = 4'h7;
  localparam logic [3:0] OP_MOVPCL = 4'h8;

  localparam logic [3:0] ALU_ADD = 4'h0;
  localparam logic [3:0] ALU_ADC = 4'h1;
  localparam logic [3:0] ALU_SUB = 4'h2;
  localparam logic [3:0] ALU_SBC = 4'h3;
  localparam logic [3:0] ALU_AND = 4'h4;
  localparam logic [3:0] ALU_OR  = 4'h5;
  localparam logic [3:0] ALU_XOR = 4'h6;
  localparam logic [3:0] ALU_CPL = 4'h7;
  localparam logic [3:0] ALU_RR  = 4'h8;
  localparam logic [3:0] ALU_RL  = 4'h9;
  localparam logic [3:0] ALU_RRC = 4'ha;
  localparam logic [3:0] ALU_RLC = 4'hb;
  localparam logic [3:0] ALU_INC = 4'hc;
  localparam logic [3:0] ALU_DEC = 4'hd;
  localparam logic [3:0] ALU_MOV = 4'he;

  // Register map (byte addresses)
  localparam logic [AXI_ADDR_W-1:0] REG_CTRL   = 5'h00;
  localparam logic [AXI_ADDR_W-1:0] REG_PCL    = 5'h04;
  localparam logic [AXI_ADDR_W-1:0] REG_STATUS = 5'h08;

  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_INTEN_BIT = 1;
  localparam logic CTRL_RUN_RESET   = 1'b1;
  localparam logic CTRL_INTEN_RESET = 1'b0;

  localparam int ST_ACC_LSB   = 0;
  localparam int ST_CARRY     = 8;
  localparam int ST_ZERO      = 9;
  localparam int ST_DEPTH_LSB = 10;
  localparam int ST_PEND      = 14;
  localparam int ST_INTEN     = 15;
  localparam int ST_PC_LSB    = 16;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam logic [1:0] SEL_CTRL   = 2'h0;
  localparam logic [1:0] SEL_PCL    = 2'h1;
  localparam logic [1:0] SEL_STATUS = 2'h2;
  localparam logic [1:0] SEL_NONE   = 2'h3;

  typedef enum logic [1:0] {PH_T1, PH_T2, PH_T3, PH_T4} phase_t;
endpackage
`default_nettype wire

// file: rtl/cpu_fetch_sequencer_stack.sv
// Functional notes
// - System clock split into four phases; one pass is one instruction cycle.
// - PC advances and next fetch starts at start of first phase.
// - Fetch of next instruction overlaps execution of current one.
// - Plain instructions take one cycle; branches and calls one more.
// - Jump or call: first cycle loads target into PC, second cycle is a dummy while target is fetched.
// - PC increments by one per instruction except control transfers.
// - PC is 4-bit high plus 8-bit low; only low byte software writable, STATUS reads all 12 bits.
// - Jump, call, interrupt and reset load the target into the PC.
// - True skip discards prefetched instruction and runs a dummy cycle.
// - Software write of PC low byte jumps in page, adds dummy cycle.
// - Eight-level return stack of PC values, not software accessible.
// - Call and interrupt acknowledge push PC; returns restore it.
// - Reset sets stack pointer to top of stack.
// - Full stack records interrupt request but withholds acknowledge.
// - Call on full stack still executes; oldest entry is lost.
// - 8-bit ALU for arithmetic, logic, rotate, inc, dec, skip decisions.
// - After reset execution starts at program address zero.
`default_nettype none
module cpu_fetch_sequencer_stack
  import cpu_seq_pkg::*;
(
  input  wire  logic                             mclk,
  input  wire  logic                             rst,
  output logic [3:0]                             instr_phase_clocks,
  output logic [cpu_seq_pkg::PC_W-1:0]           prog_addr,
  input  wire  logic [cpu_seq_pkg::INSTR_W-1:0]  prog_data,
  input  wire  logic                             irq,
  input  wire  logic [cpu_seq_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire  logic                             s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire  logic [cpu_seq_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire  logic [3:0]                       s_axi_wstrb,
  input  wire  logic                             s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire  logic                             s_axi_bready,
  input  wire  logic [cpu_seq_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire  logic                             s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [cpu_seq_pkg::AXI_DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire  logic                             s_axi_rready
);
  import cpu_seq_pkg::*;
  function automatic logic [1:0] decode(input logic [AXI_ADDR_W-1:0] a);
    logic [1:0] s;
    s = SEL_NONE;
    if (a[AXI_ADDR_W-1:2] == REG_CTRL[AXI_ADDR_W-1:2]) begin
      s = SEL_CTRL;
    end else if (a[AXI_ADDR_W-1:2] == REG_PCL[AXI_ADDR_W-1:2]) begin
      s = SEL_PCL;
    end else if (a[AXI_ADDR_W-1:2] == REG_STATUS[AXI_ADDR_W-1:2]) begin
      s = SEL_STATUS;
    end
    return s;
  endfunction
  // Returns {carry, result}; subtraction carry is the inverted borrow
  function automatic logic [DATA_W:0] alu(input logic [3:0] f, input logic [DATA_W-1:0] a,
                                          input logic [DATA_W-1:0] b, input logic c);
    logic [DATA_W:0] r;
    r = {c, a};
    case (f)
      ALU_ADD: r = {1'b0, a} + {1'b0, b};
      ALU_ADC: r = {1'b0, a} + {1'b0, b} + {8'h00, c};
      ALU_SUB: r = {1'b0, a} + {1'b0, ~b} + 9'h001;
      ALU_SBC: r = {1'b0, a} + {1'b0, ~b} + {8'h00, c};
      ALU_AND: r = {c, a & b};
      ALU_OR:  r = {c, a | b};
      ALU_XOR: r = {c, a ^ b};
      ALU_CPL: r = {c, ~a};
      ALU_RR:  r = {c, a[0], a[7:1]};
      ALU_RL:  r = {c, a[6:0], a[7]};
      ALU_RRC: r = {a[0], c, a[7:1]};
      ALU_RLC: r = {a[7], a[6:0], c};
      ALU_INC: r = {c, a + 8'h01};
      ALU_DEC: r = {c, a - 8'h01};
      ALU_MOV: r = {c, b};
      default: r = {c, a};
    endcase
    return r;
  endfunction
  phase_t                phase;
  logic                  run, inten, fetch_valid, carry, zero, int_pend, pcl_pend;
  logic                  irq_meta, irq_sync, irq_prev;
  logic [PC_W-1:0]       pc, fetch_pc, next_pc, push_val;
  logic [INSTR_W-1:0]    fetch_word, ir;
  logic [PC_W-1:0]       stack [STACK_DEPTH];
  logic [SP_W-1:0]       sp;
  logic [DEPTH_W-1:0]    depth;
  logic [DATA_W-1:0]     acc, next_acc;
  logic [PCL_W-1:0]      pcl_val;
  logic                  t1_start, exec, stack_full, xfer, skip, flush;
  logic                  do_push, do_pop, take_int, set_inten, acc_we, zero_we, next_carry;
  logic [DATA_W:0]       alu_res;
  logic [3:0]            opc, func;
  logic                  aw_held, w_held, w_lane0, wr_go;
  logic [AXI_ADDR_W-1:0] aw_addr;
  logic [AXI_DATA_W-1:0] w_data;
  logic [1:0]            wr_sel, rd_sel;
  assign opc        = ir[OPC_LSB +: 4];
  assign func       = ir[FUNC_LSB +: 4];
  assign t1_start   = run && (phase == PH_T4);
  assign exec       = run && (phase == PH_T2);
  assign stack_full = (depth == DEPTH_FULL);
  assign prog_addr  = pc;
  // Phases only advance while running; halting freezes the whole pipeline
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase <= PH_T2;
      instr_phase_clocks <= 4'h2;
    end else if (run) begin
      instr_phase_clocks <= {instr_phase_clocks[2:0], instr_phase_clocks[3]};
      case (phase)
        PH_T1: phase <= PH_T2;
        PH_T2: phase <= PH_T3;
        PH_T3: phase <= PH_T4;
        default: phase <= PH_T1;
      endcase
    end
  end
  always_comb begin
    xfer = 1'b0;
    skip = 1'b0;
    do_push = 1'b0;
    do_pop = 1'b0;
    take_int = 1'b0;
    set_inten = 1'b0;
    acc_we = 1'b0;
    zero_we = 1'b0;
    next_pc = pc;
    push_val = fetch_pc;
    alu_res = alu(func, acc, ir[DATA_W-1:0], carry);
    next_acc = alu_res[DATA_W-1:0];
    next_carry = alu_res[DATA_W];
    if (exec) begin
      if (pcl_pend) begin
        xfer = 1'b1;
        next_pc = {fetch_pc[PC_W-1:PCL_W], pcl_val};
      end else begin
        case (opc)
          OP_ALU: begin
            acc_we = 1'b1;
            zero_we = (func < ALU_RR) || (func > ALU_RLC);
          end
          OP_JMP: begin
            xfer = 1'b1;
            next_pc = ir[PC_W-1:0];
          end
          OP_CALL: begin
            xfer = 1'b1;
            do_push = 1'b1;
            next_pc = ir[PC_W-1:0];
          end
          OP_RET, OP_RETURN_FROM_INTERRUPT: begin
            xfer = 1'b1;
            set_inten = (opc == OP_RETURN_FROM_INTERRUPT);
            if (depth == '0) begin
              next_pc = RESET_VECTOR;
            end else begin
              do_pop = 1'b1;
              next_pc = stack[sp - SP_ONE];
            end
          end
          OP_SZ: skip = (acc == '0);
          OP_SDZ: begin
            alu_res = alu(ALU_DEC, acc, acc, carry);
            next_acc = alu_res[DATA_W-1:0];
            acc_we = 1'b1;
            zero_we = 1'b1;
            skip = (next_acc == '0);
          end
          OP_MOVPCL: begin
            xfer = 1'b1;
            next_pc = {fetch_pc[PC_W-1:PCL_W], acc};
          end
          default: xfer = 1'b0;
        endcase
      end
      // Acknowledge only between transfers so the pushed address is a real return point
      if (!xfer && !skip && int_pend && inten && !stack_full) begin
        take_int = 1'b1;
        xfer = 1'b1;
        do_push = 1'b1;
        next_pc = INT_VECTOR;
      end
    end
    flush = xfer || skip;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc <= RESET_VECTOR;
    end else if (exec && xfer) begin
      pc <= next_pc;
    end else if (t1_start) begin
      pc <= pc + PC_ONE;
    end
  end

  // Prefetch buffer: a flushed word enters the decoder as a dummy cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fetch_word <= NOP_WORD;
      fetch_pc <= RESET_VECTOR;
      fetch_valid <= 1'b0;
      ir <= NOP_WORD;
    end else if (t1_start) begin
      ir <= fetch_valid ? fetch_word : NOP_WORD;
      fetch_word <= prog_data;
      fetch_pc <= pc;
      fetch_valid <= 1'b1;
    end else if (exec && flush) begin
      fetch_valid <= 1'b0;
    end
  end

  // Circular store: pushing into a full stack overwrites the oldest entry
  always_ff @(posedge mclk) begin
    if (do_push) begin
      stack[sp] <= push_val;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sp <= SP_RESET;
      depth <= '0;
    end else if (do_push) begin
      sp <= sp + SP_ONE;
      depth <= stack_full ? depth : depth + DEPTH_ONE;
    end else if (do_pop) begin
      sp <= sp - SP_ONE;
      depth <= depth - DEPTH_ONE;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc <= '0;
      carry <= 1'b0;
      zero <= 1'b0;
    end else if (acc_we) begin
      acc <= next_acc;
      carry <= next_carry;
      if (zero_we) begin
        zero <= (next_acc == '0);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
      irq_prev <= 1'b0;
    end else begin
      irq_meta <= irq;
      irq_sync <= irq_meta;
      irq_prev <= irq_sync;
    end
  end

  // New request edge wins over the acknowledge that clears the flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      int_pend <= 1'b0;
    end else if (irq_sync && !irq_prev) begin
      int_pend <= 1'b1;
    end else if (take_int) begin
      int_pend <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run <= CTRL_RUN_RESET;
      inten <= CTRL_INTEN_RESET;
    end else if (wr_go && wr_sel == SEL_CTRL && w_lane0) begin
      run <= w_data[CTRL_RUN_BIT];
      inten <= w_data[CTRL_INTEN_BIT];
    end else if (take_int) begin
      inten <= 1'b0;
    end else if (set_inten) begin
      inten <= 1'b1;
    end
  end

  // A fresh write wins over consumption; it is applied at the next execute slot
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pcl_pend <= 1'b0;
      pcl_val <= '0;
    end else if (wr_go && wr_sel == SEL_PCL && w_lane0) begin
      pcl_pend <= 1'b1;
      pcl_val <= w_data[PCL_W-1:0];
    end else if (exec) begin
      pcl_pend <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel        = decode(aw_addr);
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held <= 1'b0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == SEL_CTRL || wr_sel == SEL_PCL) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_sel        = decode(s_axi_araddr);

  // The stack and its pointer never appear in the read map
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      if (rd_sel == SEL_CTRL) begin
        s_axi_rdata[CTRL_RUN_BIT] <= run;
        s_axi_rdata[CTRL_INTEN_BIT] <= inten;
      end else if (rd_sel == SEL_PCL) begin
        s_axi_rdata[PCL_W-1:0] <= pc[PCL_W-1:0];
      end else if (rd_sel == SEL_STATUS) begin
        s_axi_rdata[ST_ACC_LSB +: DATA_W] <= acc;
        s_axi_rdata[ST_CARRY] <= carry;
        s_axi_rdata[ST_ZERO] <= zero;
        s_axi_rdata[ST_DEPTH_LSB +: DEPTH_W] <= depth;
        s_axi_rdata[ST_PEND] <= int_pend;
        s_axi_rdata[ST_INTEN] <= inten;
        s_axi_rdata[ST_PC_LSB +: PC_W] <= pc;
      end else begin
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: bench/cpu_seq_chk.sv
`default_nettype none
module cpu_seq_chk
  import cpu_seq_pkg::*;
(
  input wire logic                        mclk,
  input wire logic                        rst,
  input wire logic [3:0]                  instr_phase_clocks,
  input wire logic [cpu_seq_pkg::PC_W-1:0] prog_addr,
  input wire logic                        s_axi_awvalid,
  input wire logic                        s_axi_awready,
  input wire logic                        s_axi_wvalid,
  input wire logic                        s_axi_wready,
  input wire logic [1:0]                  s_axi_bresp,
  input wire logic                        s_axi_bvalid,
  input wire logic                        s_axi_bready,
  input wire logic                        s_axi_arvalid,
  input wire logic                        s_axi_arready,
  input wire logic [31:0]                 s_axi_rdata,
  input wire logic                        s_axi_rvalid,
  input wire logic                        s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire [3:0] ph = instr_phase_clocks;

  a_phase_onehot: assert property ($onehot(ph))
    else $error("phase not one-hot");
  a_phase_rotate: assert property (!$stable(ph) |-> ph == (($past(ph) << 1) | ($past(ph) >> 3)))
    else $error("phase skipped a step");
  a_fetch_step: assert property ($rose(ph[0]) |-> prog_addr == $past(prog_addr) + PC_ONE)
    else $error("address not advanced at first phase");
  // Address may only move entering the first or third phase
  a_addr_steady: assert property ((ph[1] || ph[3]) |-> $stable(prog_addr))
    else $error("address moved outside fetch or execute slot");
  a_reset_entry: assert property ($past(rst) |-> ph == 4'h2 && prog_addr == RESET_VECTOR)
    else $error("wrong state after reset");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule
bind cpu_fetch_sequencer_stack cpu_seq_chk u_cpu_seq_chk (
  .mclk(mclk), .rst(rst), .instr_phase_clocks(instr_phase_clocks), .prog_addr(prog_addr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

// file: bench/program_store.sv
`default_nettype none
module program_store
  import cpu_seq_pkg::*;
#(
  parameter bit SLOW = 1'b1
)
(
  input  wire logic                           mclk,
  input  wire logic [cpu_seq_pkg::PC_W-1:0]    prog_addr,
  output logic      [cpu_seq_pkg::INSTR_W-1:0] prog_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [INSTR_W-1:0] mem [0:4095];
  logic [INSTR_W-1:0] q;
  // Slow mode answers one cycle late, the worst the fetch timing allows
  always_ff @(posedge mclk) begin
    q <= mem[prog_addr];
  end
  assign prog_data = SLOW ? q : mem[prog_addr];
endmodule
`default_nettype wire

// file: bench/tb.sv
`default_nettype none
module tb;
  import cpu_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  mclk, rst, irq;
  logic [3:0]            phase;
  logic [PC_W-1:0]       prog_addr;
  logic [INSTR_W-1:0]    prog_data;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]           wdata, rdata, rd;
  logic [1:0]            bresp, rresp, rsp;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  int                    fail_count, comparisons;

  cpu_fetch_sequencer_stack u_cpu_fetch_sequencer_stack (
    .mclk(mclk), .rst(rst), .instr_phase_clocks(phase), .prog_addr(prog_addr),
    .prog_data(prog_data), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  program_store #(.SLOW(1'b1)) u_program_store (
    .mclk(mclk), .prog_addr(prog_addr), .prog_data(prog_data));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic timeout();
    fail_count++;
    $display("ERROR bus wait expected answer seen none");
    give_verdict();
  endtask

  task automatic axi_wr(input logic [AXI_ADDR_W-1:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge mclk);
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready) && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) timeout();
  endtask

  task automatic axi_rd(input logic [AXI_ADDR_W-1:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    @(posedge mclk);
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready) && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) timeout();
  endtask

  task automatic clr();
    for (int i = 0; i < 4096; i++) u_program_store.mem[i] = NOP_WORD;
  endtask

  task automatic reset_run(input int cyc);
    rst <= 1'b1;
    repeat (20) @(posedge mclk);
    check("reset phase", 32'h2, {28'h0, phase});
    check("reset address", 32'h0, {20'h0, prog_addr});
    rst <= 1'b0;
    repeat (cyc) @(posedge mclk);
  endtask

  task automatic status(input string nm, input logic [31:0] mask, input logic [31:0] exp);
    axi_rd(REG_STATUS, rd, rsp);
    check(nm, exp, rd & mask);
  endtask

  task automatic pulse_irq();
    irq <= 1'b1;
    repeat (8) @(posedge mclk);
    irq <= 1'b0;
    repeat (80) @(posedge mclk);
  endtask

  function automatic logic [31:0] st(input logic [7:0] acc, input logic c, z,
                                     input logic [3:0] d, input logic p, i);
    return {16'h0, i, p, d, z, c, acc};
  endfunction

  // Carry is clear after reset, so the carry-in forms act as plain add and borrow
  function automatic logic [7:0] alu_exp(input logic [3:0] f, input logic [7:0] a, b);
    case (f)
      ALU_ADD, ALU_ADC: return a + b;
      ALU_SUB: return a - b;
      ALU_SBC: return a - b - 8'h01;
      ALU_AND: return a & b;
      ALU_OR:  return a | b;
      ALU_XOR: return a ^ b;
      ALU_CPL: return ~a;
      ALU_RR:  return {a[0], a[7:1]};
      ALU_RL:  return {a[6:0], a[7]};
      ALU_RRC: return {1'b0, a[7:1]};
      ALU_RLC: return {a[6:0], 1'b0};
      ALU_INC: return a + 8'h01;
      ALU_DEC: return a - 8'h01;
      default: return b;
    endcase
  endfunction

  initial begin
    {rst, irq, awvalid, wvalid, bready, arvalid, rready} = 7'h40;
    {awaddr, araddr, wdata} = '0;
    fail_count = 0;
    comparisons = 0;
    for (int f = 0; f < 15; f++) begin
      clr();
      u_program_store.mem[0] = 16'h1e96;
      u_program_store.mem[1] = {4'h1, f[3:0], 8'h3c};
      u_program_store.mem[2] = 16'h2002;
      reset_run(80);
      status("alu result", 32'hff, {24'h0, alu_exp(f[3:0], 8'h96, 8'h3c)});
    end
    $display("test alu done");
    clr();
    u_program_store.mem[0] = 16'h1eff;
    u_program_store.mem[1] = 16'h1001;
    u_program_store.mem[2] = 16'h6000;
    u_program_store.mem[3] = 16'h1e55;
    u_program_store.mem[4] = 16'h2004;
    reset_run(80);
    status("skip flags", 32'hffff, st(8'h00, 1'b1, 1'b1, 4'h0, 1'b0, 1'b0));
    axi_rd(REG_CTRL, rd, rsp);
    check("ctrl reset", 32'h1, rd & 32'h3);
    axi_wr(REG_STATUS, 32'h0, rsp);
    check("status write resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    axi_rd(5'h0c, rd, rsp);
    check("unmapped read", {30'h0, RESP_SLVERR}, {rd[29:0], rsp});
    $display("test skip done");
    clr();
    u_program_store.mem[0] = 16'h3010;
    u_program_store.mem[1] = 16'h1e33;
    u_program_store.mem[2] = 16'h2002;
    u_program_store.mem[16] = 16'h1e77;
    u_program_store.mem[17] = 16'h4000;
    reset_run(80);
    status("call return", 32'hffff, st(8'h33, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0));
    $display("test call done");
    // First pass skips the jump; the return on an empty stack must restart at zero
    clr();
    u_program_store.mem[0] = 16'h6000;
    u_program_store.mem[1] = 16'h2005;
    u_program_store.mem[2] = 16'h1e42;
    u_program_store.mem[3] = 16'h4000;
    u_program_store.mem[5] = 16'h2005;
    reset_run(80);
    status("empty return", 32'h0ffcffff, 32'h00040042);
    $display("test empty return done");
    // Nine nested calls overflow the stack, then an interrupt must wait for a free level
    clr();
    u_program_store.mem[0] = 16'h2010;
    for (int k = 0; k < 9; k++) u_program_store.mem[16 + k] = 16'h3011 + 16'(k);
    u_program_store.mem[25] = 16'h2019;
    u_program_store.mem[26] = 16'h4000;
    u_program_store.mem[4] = 16'h1e99;
    u_program_store.mem[5] = 16'h2005;
    reset_run(120);
    axi_wr(REG_CTRL, 32'h3, rsp);
    pulse_irq();
    status("full stack", 32'hffff, st(8'h00, 1'b0, 1'b0, 4'h8, 1'b1, 1'b1));
    axi_wr(REG_PCL, 32'h1a, rsp);
    check("pcl write resp", {30'h0, RESP_OKAY}, {30'h0, rsp});
    repeat (80) @(posedge mclk);
    status("held interrupt", 32'hffff, st(8'h99, 1'b0, 1'b0, 4'h8, 1'b0, 1'b0));
    $display("test stack done");
    clr();
    u_program_store.mem[0] = 16'h2120;
    u_program_store.mem[288] = 16'h2120;
    u_program_store.mem[320] = 16'h1e5a;
    u_program_store.mem[321] = 16'h2141;
    reset_run(40);
    axi_wr(REG_PCL, 32'h40, rsp);
    repeat (40) @(posedge mclk);
    status("page jump", 32'h0f0000ff, 32'h0100005a);
    $display("test page done");
    give_verdict();
  end
endmodule
`default_nettype wire
